// >>> design/cwt_consts.svh
// constants of the cyclic wake timer block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef CWT_CONSTS_SVH
`define CWT_CONSTS_SVH
// clock and base tick
`define CWT_CLK_MHZ 25
`define CWT_TICK_US 100
`define CWT_TICK_CYC ((`CWT_TICK_US * `CWT_CLK_MHZ))
`define CWT_PRE_W 12
// period choices, microseconds
`define CWT_PER0_US 10000
`define CWT_PER1_US 20000
`define CWT_PER2_US 50000
`define CWT_PER3_US 100000
`define CWT_PER4_US 200000
`define CWT_PER5_US 1000000
`define CWT_PER6_US 2000000
// on-time choices, microseconds
`define CWT_ON1_US 100
`define CWT_ON2_US 300
`define CWT_ON3_US 1000
`define CWT_ON4_US 10000
`define CWT_ON5_US 20000
// tick counter width
`define CWT_TW 15
// field layout of a timer control word: period [2:0], on-time [5:3]
`define CWT_PER_LSB 0
`define CWT_PER_MSB 2
`define CWT_ON_LSB 3
`define CWT_ON_MSB 5
`define CWT_TCTL_RST 6'h00
// high-side map fields, two bits per output
`define CWT_MAP_W 2
`define CWT_MAP_RST 2'h0
`endif

// >>> design/cwt_pkg.sv
// types of the cyclic wake timer block
package cwt_pkg;
  typedef enum logic [1:0] {CWT_NORMAL = 2'h0, CWT_STOP = 2'h1, CWT_SLEEP = 2'h2,
    CWT_FAILSAFE = 2'h3} cwt_mode_e;
  typedef enum logic [2:0] {CWT_ON_OFF_LOW = 3'h0, CWT_ON_0P1 = 3'h1, CWT_ON_0P3 = 3'h2,
    CWT_ON_1P0 = 3'h3, CWT_ON_10 = 3'h4, CWT_ON_20 = 3'h5, CWT_ON_OFF_HIGH = 3'h6,
    CWT_ON_RSVD = 3'h7} cwt_on_e;
  typedef enum logic [1:0] {CWT_HS_OFF = 2'h0, CWT_HS_T1 = 2'h1, CWT_HS_T2 = 2'h2,
    CWT_HS_ON = 2'h3} cwt_hs_e;
  typedef enum logic [2:0] {CWT_T_IDLE = 3'h1, CWT_T_FIRST = 3'h2, CWT_T_RUN = 3'h4} cwt_tst_e;
endpackage : cwt_pkg

// >>> design/cwt_tmr_if.sv
// link between the control logic and one timer engine
`timescale 1ns/1ps
`default_nettype none
`include "cwt_consts.svh"
interface cwt_tmr_if;
  logic tick;
  logic start;
  logic stop;
  logic [`CWT_TW-1:0] per_ticks;
  logic [`CWT_TW-1:0] on_ticks;
  logic phase_start;
  logic active;
  modport ctl (output tick, start, stop, per_ticks, on_ticks, input phase_start, active);
  modport tmr (input tick, start, stop, per_ticks, on_ticks, output phase_start, active);
endinterface : cwt_tmr_if
`default_nettype wire

// >>> design/cwt_timer.sv
// one periodic timer engine
`timescale 1ns/1ps
`default_nettype none
`include "cwt_consts.svh"
module cwt_timer
  import cwt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  cwt_tmr_if.tmr t
);
  cwt_tst_e state_reg;
  logic [`CWT_TW-1:0] cnt_reg;
  logic last_tick;

  assign last_tick = (cnt_reg == t.per_ticks - `CWT_TW'(1));

  // ----------------------------------------------------------------------
  // sequence: idle, first phase without interrupt, then running
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state_reg <= CWT_T_IDLE;
    else if (ce)
    begin
      case (state_reg)
        CWT_T_IDLE: if (t.start) state_reg <= CWT_T_FIRST;
        CWT_T_FIRST:
        begin
          if (t.stop) state_reg <= CWT_T_IDLE;
          else if (t.start) state_reg <= CWT_T_FIRST;
          else if (t.tick && last_tick) state_reg <= CWT_T_RUN;
        end
        CWT_T_RUN:
        begin
          if (t.stop) state_reg <= CWT_T_IDLE;
          else if (t.start) state_reg <= CWT_T_FIRST;
        end
        default: state_reg <= CWT_T_IDLE;
      endcase
    end
  end

  // tick counter inside one period; a restart begins a fresh first phase
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt_reg <= '0;
    else if (ce)
    begin
      if (t.start || state_reg == CWT_T_IDLE)
        cnt_reg <= '0;
      else if (t.tick)
        cnt_reg <= last_tick ? '0 : cnt_reg + `CWT_TW'(1);
    end
  end

  // one pulse per phase start, never for the first phase
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      t.phase_start <= 1'b0;
    else if (ce)
      t.phase_start <= t.tick && last_tick && !t.start && !t.stop
        && state_reg != CWT_T_IDLE;
  end

  // active while inside the on-time part of the period
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      t.active <= 1'b0;
    else if (ce)
      t.active <= (state_reg != CWT_T_IDLE || t.start) && !t.stop
        && (t.start ? 1'b1 : (cnt_reg < t.on_ticks));
  end
endmodule : cwt_timer
`default_nettype wire

// >>> design/cwt_top.sv
// cyclic wake timers: configuration, two timers, high-side mapping, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cwt_consts.svh"
module cwt_top
  import cwt_pkg::*;
#(
  parameter int N_HS = 4,
  parameter int TICK_CYC = `CWT_TICK_CYC
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [1:0] mode,
  input wire logic wake_ctl_wr,
  input wire logic [1:0] wake_ctl_wdata,
  input wire logic tctl1_wr,
  input wire logic tctl2_wr,
  input wire logic [5:0] tctl_wdata,
  input wire logic hs_ctl1_wr,
  input wire logic hs_ctl2_wr,
  input wire logic [2*`CWT_MAP_W-1:0] hs_ctl_wdata,
  input wire logic wake_clr,
  input wire logic cfg_fail_clr,
  output logic int_n,
  output logic [1:0] wake_flag,
  output logic cfg_fail,
  output logic [N_HS-1:0] hs_out,
  output logic [1:0] tmr_state,
  output logic [1:0] wake_en,
  output logic [5:0] tctl1_q,
  output logic [5:0] tctl2_q
);
  initial
  begin
    if (N_HS < 1 || N_HS > 4)
      $error("cwt_top: N_HS must lie between 1 and 4");
    // the prescaler must wrap inside its own width
    if (TICK_CYC < 2 || TICK_CYC > (1 << `CWT_PRE_W))
      $error("cwt_top: TICK_CYC does not fit the prescaler");
  end

  // ----------------------------------------------------------------------
  // tick lookups
  // ----------------------------------------------------------------------
  // period code to 0.1 ms ticks; code 7 is unused and treated as longest
  function automatic logic [`CWT_TW-1:0] per_lut(input logic [2:0] c);
    case (c)
      3'h0: per_lut = `CWT_TW'(`CWT_PER0_US / `CWT_TICK_US);
      3'h1: per_lut = `CWT_TW'(`CWT_PER1_US / `CWT_TICK_US);
      3'h2: per_lut = `CWT_TW'(`CWT_PER2_US / `CWT_TICK_US);
      3'h3: per_lut = `CWT_TW'(`CWT_PER3_US / `CWT_TICK_US);
      3'h4: per_lut = `CWT_TW'(`CWT_PER4_US / `CWT_TICK_US);
      3'h5: per_lut = `CWT_TW'(`CWT_PER5_US / `CWT_TICK_US);
      default: per_lut = `CWT_TW'(`CWT_PER6_US / `CWT_TICK_US);
    endcase
  endfunction : per_lut

  // on-time code to ticks; off codes give zero
  function automatic logic [`CWT_TW-1:0] on_lut(input logic [2:0] c);
    case (c)
      CWT_ON_0P1: on_lut = `CWT_TW'(`CWT_ON1_US / `CWT_TICK_US);
      CWT_ON_0P3: on_lut = `CWT_TW'(`CWT_ON2_US / `CWT_TICK_US);
      CWT_ON_1P0: on_lut = `CWT_TW'(`CWT_ON3_US / `CWT_TICK_US);
      CWT_ON_10: on_lut = `CWT_TW'(`CWT_ON4_US / `CWT_TICK_US);
      CWT_ON_20: on_lut = `CWT_TW'(`CWT_ON5_US / `CWT_TICK_US);
      default: on_lut = '0;
    endcase
  endfunction : on_lut

  // an on-time code that runs the timer
  function automatic logic on_runs(input logic [2:0] c);
    on_runs = (c >= CWT_ON_0P1) && (c <= CWT_ON_20);
  endfunction : on_runs

  // ----------------------------------------------------------------------
  // base tick of 0.1 ms
  // ----------------------------------------------------------------------
  localparam logic [`CWT_PRE_W-1:0] PRE_LAST = `CWT_PRE_W'(TICK_CYC - 1);
  logic [`CWT_PRE_W-1:0] pre_reg;
  logic tick_reg;

  // free-running prescaler; both timers share it, so a start may land anywhere
  // within the current 0.1 ms tick (up to one tick of phase jitter)
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pre_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_reg <= (pre_reg == PRE_LAST);
      pre_reg <= (pre_reg == PRE_LAST) ? '0 : pre_reg + `CWT_PRE_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [5:0] tctl_reg [2];
  logic [1:0] wake_en_reg;
  logic [`CWT_MAP_W-1:0] hs_map_reg [4];
  logic [1:0] start_reg;
  logic [1:0] stop_reg;
  logic [1:0] twr;

  assign twr = {tctl2_wr, tctl1_wr};

  // wake-source enables, one bit per timer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_en_reg <= 2'h0;
    else if (ce && wake_ctl_wr)
      wake_en_reg <= wake_ctl_wdata;
  end

  // high-side maps: first register holds outputs 0 and 1, second 2 and 3
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
        hs_map_reg[i] <= `CWT_MAP_RST;
    end
    else if (ce)
    begin
      if (hs_ctl1_wr)
      begin
        hs_map_reg[0] <= hs_ctl_wdata[`CWT_MAP_W-1:0];
        hs_map_reg[1] <= hs_ctl_wdata[2*`CWT_MAP_W-1:`CWT_MAP_W];
      end
      if (hs_ctl2_wr)
      begin
        hs_map_reg[2] <= hs_ctl_wdata[`CWT_MAP_W-1:0];
        hs_map_reg[3] <= hs_ctl_wdata[2*`CWT_MAP_W-1:`CWT_MAP_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // per-timer control and engines
  // ----------------------------------------------------------------------
  logic [1:0] phase;
  logic [1:0] act;
  logic [1:0] level;
  logic [1:0] bad;

  for (genvar g = 0; g < 2; g++)
  begin : g_tmr
    cwt_tmr_if tif ();

    // own control word per timer; a write of a running on-time (re)starts it,
    // an off code stops it, independent of enable or mapping
    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
      begin
        tctl_reg[g] <= `CWT_TCTL_RST;
        start_reg[g] <= 1'b0;
        stop_reg[g] <= 1'b0;
      end
      else if (ce)
      begin
        start_reg[g] <= twr[g] && on_runs(tctl_wdata[`CWT_ON_MSB:`CWT_ON_LSB]);
        stop_reg[g] <= twr[g] && !on_runs(tctl_wdata[`CWT_ON_MSB:`CWT_ON_LSB]);
        if (twr[g])
          tctl_reg[g] <= tctl_wdata;
      end
    end

    assign tif.tick = tick_reg;
    assign tif.start = start_reg[g];
    assign tif.stop = stop_reg[g];
    assign tif.per_ticks = per_lut(tctl_reg[g][`CWT_PER_MSB:`CWT_PER_LSB]);
    assign tif.on_ticks = on_lut(tctl_reg[g][`CWT_ON_MSB:`CWT_ON_LSB]);
    assign phase[g] = tif.phase_start;
    assign act[g] = tif.active;

    // output level: off codes pin the level, otherwise the on-time phase
    assign level[g] = (tctl_reg[g][`CWT_ON_MSB:`CWT_ON_LSB] == CWT_ON_OFF_HIGH) ? 1'b1
      : on_runs(tctl_reg[g][`CWT_ON_MSB:`CWT_ON_LSB]) && tif.active;

    // on-time longer than period is flagged on the write
    assign bad[g] = twr[g] && (on_lut(tctl_wdata[`CWT_ON_MSB:`CWT_ON_LSB])
      > per_lut(tctl_wdata[`CWT_PER_MSB:`CWT_PER_LSB]));

    cwt_timer u_tmr (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ce(ce),
      .t(tif.tmr)
    );
  end

  // ----------------------------------------------------------------------
  // status, flags and interrupt
  // ----------------------------------------------------------------------
  logic irq_mode;
  logic [1:0] wake_set;

  assign irq_mode = (mode == CWT_NORMAL) || (mode == CWT_STOP);
  assign wake_set = phase & wake_en_reg & {2{irq_mode}};

  // sticky wake flags; a new event in the clear cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wake_flag <= 2'h0;
    else if (ce)
      wake_flag <= (wake_clr ? 2'h0 : wake_flag) | wake_set;
  end

  // interrupt low while a wake flag stands or is being set
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      int_n <= 1'b1;
    else if (ce)
      int_n <= !(|((wake_clr ? 2'h0 : wake_flag) | wake_set));
  end

  // configuration failure flag; accepted anyway, set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cfg_fail <= 1'b0;
    else if (ce)
      cfg_fail <= (cfg_fail && !cfg_fail_clr) || (|bad);
  end

  // mapped high-side drive, registered so the pins never glitch
  for (genvar h = 0; h < N_HS; h++)
  begin : g_hs
    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        hs_out[h] <= 1'b0;
      else if (ce)
      begin
        case (hs_map_reg[h])
          CWT_HS_T1: hs_out[h] <= level[0];
          CWT_HS_T2: hs_out[h] <= level[1];
          CWT_HS_ON: hs_out[h] <= 1'b1;
          default: hs_out[h] <= 1'b0;
        endcase
      end
    end
  end

  // readback copies of configuration and timer activity
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tmr_state <= 2'h0;
      wake_en <= 2'h0;
      tctl1_q <= `CWT_TCTL_RST;
      tctl2_q <= `CWT_TCTL_RST;
    end
    else if (ce)
    begin
      tmr_state <= act;
      wake_en <= wake_en_reg;
      tctl1_q <= tctl_reg[0];
      tctl2_q <= tctl_reg[1];
    end
  end
endmodule : cwt_top
`default_nettype wire

// >>> sim/cwt_top_monitor.sv
// port checker of the cyclic wake timers
`timescale 1ns/1ps
`default_nettype none
module cwt_top_monitor
  import cwt_pkg::*;
#(
  parameter int N_HS = 4
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [1:0] mode,
  input wire logic wake_ctl_wr,
  input wire logic [1:0] wake_ctl_wdata,
  input wire logic tctl1_wr,
  input wire logic tctl2_wr,
  input wire logic [5:0] tctl_wdata,
  input wire logic hs_ctl1_wr,
  input wire logic hs_ctl2_wr,
  input wire logic [3:0] hs_ctl_wdata,
  input wire logic wake_clr,
  input wire logic cfg_fail_clr,
  input wire logic int_n,
  input wire logic [1:0] wake_flag,
  input wire logic cfg_fail,
  input wire logic [N_HS-1:0] hs_out,
  input wire logic [1:0] tmr_state,
  input wire logic [1:0] wake_en,
  input wire logic [5:0] tctl1_q,
  input wire logic [5:0] tctl2_q
);
  // single domain, so one clock and one disable for all
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // interrupt line is the inverted or of the sticky flags
  a_int_mirrors_flags: assert property (int_n == !(|wake_flag))
    else $error("int_n disagrees with wake flags");
  // the readback copy lags the enable by one edge, so it lines up with the flag
  a_flag_needs_enable: assert property ((wake_flag & ~$past(wake_flag) & ~wake_en) == 2'h0)
    else $error("wake flag set without enable");
  a_flag_needs_mode: assert property (|(wake_flag & ~$past(wake_flag)) |-> $past(mode) <= 2'h1)
    else $error("wake flag set outside normal or stop");
  a_flag_fall_cause: assert property ($fell(|wake_flag) |-> $past(wake_clr) || $past(sys_rst))
    else $error("wake flag dropped without clear");
  // only a 20 ms on-time against the 10 ms period exceeds its period
  a_cfg_fail_set: assert property ((tctl1_wr || tctl2_wr) && ce && tctl_wdata == 6'h28 |=> cfg_fail)
    else $error("on-time above period not flagged");
  a_cfg_fail_cause: assert property ($rose(cfg_fail)
    |-> $past((tctl1_wr || tctl2_wr) && ce && tctl_wdata == 6'h28))
    else $error("config failure without cause");
  a_readback_first: assert property (ce && tctl1_wr ##1 ce && !tctl1_wr
    |=> tctl1_q == $past(tctl_wdata, 2))
    else $error("first timer word readback wrong");
  a_readback_second: assert property (ce && tctl2_wr ##1 ce && !tctl2_wr
    |=> tctl2_q == $past(tctl_wdata, 2))
    else $error("second timer word readback wrong");
  a_start_on_write: assert property (ce && tctl1_wr && tctl_wdata[5:3] inside {[3'h1:3'h5]}
    ##1 (ce && !tctl1_wr)[*2] |=> tmr_state[0])
    else $error("timer did not start on on-time write");
  a_off_stops: assert property (ce && tctl2_wr && !(tctl_wdata[5:3] inside {[3'h1:3'h5]})
    ##1 (ce && !tctl2_wr)[*3] |-> !tmr_state[1])
    else $error("timer active under off setting");
endmodule : cwt_top_monitor
bind cwt_top cwt_top_monitor #(.N_HS(N_HS)) u_monitor (.*);
`default_nettype wire

// >>> sim/cwt_host_model.sv
// host model: drives the wake timer configuration strobes
`timescale 1ns/1ps
`default_nettype none
module cwt_host_model
(
  input wire logic clk_sys,
  output logic [1:0] mode,
  output logic wake_ctl_wr,
  output logic [1:0] wake_ctl_wdata,
  output logic tctl1_wr,
  output logic tctl2_wr,
  output logic [5:0] tctl_wdata,
  output logic hs_ctl1_wr,
  output logic hs_ctl2_wr,
  output logic [3:0] hs_ctl_wdata,
  output logic wake_clr,
  output logic cfg_fail_clr
);
  logic [6:0] strobes = 7'h00;
  logic [5:0] dat = 6'h00;
  logic [1:0] mode_reg = 2'h0;
  // one-hot strobes: 0 wake, 1/2 timers, 3/4 high side, 5/6 clears
  assign {cfg_fail_clr, wake_clr, hs_ctl2_wr, hs_ctl1_wr} = strobes[6:3];
  assign {tctl2_wr, tctl1_wr, wake_ctl_wr} = strobes[2:0];
  assign tctl_wdata = dat;
  assign wake_ctl_wdata = dat[1:0];
  assign hs_ctl_wdata = dat[3:0];
  assign mode = mode_reg;
  // held a full cycle so exactly one rising edge takes it
  task automatic put(input int k, input logic [5:0] d);
    @(negedge clk_sys);
    dat = d;
    strobes = 7'h01 << k;
    @(negedge clk_sys);
    strobes = 7'h00;
  endtask : put
  task automatic set_mode(input logic [1:0] m);
    @(negedge clk_sys);
    mode_reg = m;
  endtask : set_mode
  // stop first so arming cannot raise a stray interrupt
  task automatic arm(input logic [1:0] en, input logic [5:0] w);
    put(1, 6'h00);
    put(2, 6'h00);
    put(0, {4'h0, en});
    if (en[0]) put(1, w);
    if (en[1]) put(2, w);
  endtask : arm
endmodule : cwt_host_model
`default_nettype wire

// >>> sim/cyclic_wake_timers_tb_top.sv
// self-checking bench of the cyclic wake timers
`timescale 1ns/1ps
`default_nettype none
`include "cwt_consts.svh"
module cyclic_wake_timers_tb_top;
  import cwt_pkg::*;
  logic clk_sys, sys_rst, ce, wake_ctl_wr, tctl1_wr, tctl2_wr, hs_ctl1_wr, hs_ctl2_wr;
  logic wake_clr, cfg_fail_clr, int_n, cfg_fail;
  logic [1:0] mode, wake_ctl_wdata, wake_flag, tmr_state, wake_en;
  logic [5:0] tctl_wdata, tctl1_q, tctl2_q, w1, w2;
  logic [3:0] hs_ctl_wdata, hs_out;
  int errors = 0;
  int n_compared = 0;
  int rnd, n;
  logic exp_fail;
  // behavioural tables in microseconds; off codes carry no on-time
  int per_us[8] = '{10000, 20000, 50000, 100000, 200000, 1000000, 2000000, 2000000};
  int on_us[8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
  // shortened base tick keeps the three shortest periods within a few thousand cycles
  localparam int TICK = 10;
  cwt_top #(.N_HS(4), .TICK_CYC(TICK)) DUT (.*);
  cwt_host_model host (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // the tests span just over three shortest periods; allow eight of them
  initial
  begin
    repeat (8 * (`CWT_PER0_US / `CWT_TICK_US) * TICK) @(posedge clk_sys);
    errors++;
    final_report();
  end
  initial
  begin
    ce = 1'b1;
    sys_rst = 1'b1;
    rnd = $urandom(54);
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    check({int_n, wake_flag, cfg_fail, hs_out, tmr_state, wake_en}, 16'h0800);
    check({tctl1_q, tctl2_q}, 16'h0000);
    // random control words on both timers, failure flag tracked by the model
    exp_fail = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      w1 = 6'($urandom);
      w2 = 6'($urandom);
      exp_fail |= (on_us[w1[5:3]] > per_us[w1[2:0]]) || (on_us[w2[5:3]] > per_us[w2[2:0]]);
      host.put(1, w1);
      host.put(2, w2);
      host.put(0, {4'h0, w1[1:0]});
      repeat (2) @(negedge clk_sys);
      check({tctl1_q, tctl2_q}, {w1, w2});
      check(wake_en, w1[1:0]);
      check(cfg_fail, exp_fail);
    end
    $display("test readback done");
    // every on code against the shortest period
    for (int k = 0; k < 8; k++)
    begin
      host.put(6, 6'h00);
      host.put(2, {3'(k), 3'h0});
      @(negedge clk_sys);
      check(cfg_fail, on_us[k] > per_us[0]);
    end
    $display("test config failure done");
    // off-high on timer one, maps: out0 timer1, out1 on, out2 timer2, out3 off
    host.put(1, 6'h30);
    host.put(3, 6'h0D);
    host.put(4, 6'h02);
    repeat (4) @(negedge clk_sys);
    check(hs_out, 4'h3);
    host.put(1, 6'h00);
    host.put(2, 6'h30);
    repeat (4) @(negedge clk_sys);
    check(hs_out, 4'h6);
    $display("test high side done");
    // cyclic wake in stop mode: first phase silent, second one interrupts
    host.arm(2'h1, 6'h08);
    host.set_mode(2'h1);
    repeat (TICK * (per_us[0] / `CWT_TICK_US - 2)) @(negedge clk_sys);
    check({int_n, wake_flag}, 16'h4);
    for (n = 0; n < 4 * TICK && int_n !== 1'b0; n++) @(negedge clk_sys);
    check({int_n, wake_flag}, 16'h1);
    host.put(5, 6'h00);
    @(negedge clk_sys);
    check({int_n, wake_flag}, 16'h4);
    // sleep mode: the next phase start passes without an interrupt
    host.set_mode(2'h2);
    repeat (TICK * (per_us[0] / `CWT_TICK_US + 10)) @(negedge clk_sys);
    check({int_n, wake_flag}, 16'h4);
    // back in normal mode the following phase start interrupts again
    host.set_mode(2'h0);
    for (n = 0; n < TICK * (per_us[0] / `CWT_TICK_US + 10) && int_n !== 1'b0; n++)
      @(negedge clk_sys);
    check({int_n, wake_flag}, 16'h1);
    // the on-time phase that just began shows as activity
    @(negedge clk_sys);
    check(tmr_state, 2'h1);
    host.put(1, 6'h00);
    repeat (3) @(negedge clk_sys);
    check(tmr_state, 2'h0);
    $display("test cyclic wake done");
    final_report();
  end
endmodule : cyclic_wake_timers_tb_top
`default_nettype wire
